// *** hdl/internal_data_memory_decoder.sv ***
// Internal data memory: 256-byte scratch RAM, direct/indirect decode,
// register banks, bit region, special register routing, reset
// qualification and external interrupt one edge detection.
// Assumes the execute stage holds a request for one cycle and waits
// for the acknowledge before the next.
`default_nettype none
module internal_data_memory_decoder
  import idm_pkg::*;
(
  // Clock and reset
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  // Reset pin and qualified core reset
  input wire logic reset_pin_i,
  output logic core_rst_o,
  // Execute stage access port
  input wire logic acc_req_i,
  input wire op_t acc_op_i,
  input wire logic [ADDR_W-1:0] acc_addr_i,
  input wire logic [DATA_W-1:0] acc_wdata_i,
  input wire logic [1:0] psw_bank_i,
  output logic acc_ack_o,
  output logic acc_err_o,
  output logic [DATA_W-1:0] acc_rdata_o,
  output logic acc_bit_o,
  // Special register space
  output logic sfr_req_o,
  output logic sfr_we_o,
  output logic [ADDR_W-1:0] sfr_addr_o,
  output logic [DATA_W-1:0] sfr_wdata_o,
  output logic [1:0] sfr_bit_op_o,
  output logic [2:0] sfr_bit_idx_o,
  input wire logic sfr_ack_i,
  input wire logic [DATA_W-1:0] sfr_rdata_i,
  // External interrupt one
  input wire logic port1_bit0_irq_pin_i,
  input wire logic irq_both_edges_i,
  output logic ext_irq_one_o
);
  typedef struct packed {
    acc_state_t state;
    logic core_rst;
    logic ack;
    logic err;
    logic [DATA_W-1:0] rdata;
    logic bit_val;
    logic sfr_req;
    logic sfr_we;
    logic [ADDR_W-1:0] sfr_addr;
    logic [DATA_W-1:0] sfr_wdata;
    logic [1:0] sfr_bit_op;
    logic [2:0] sfr_bit_idx;
    logic [2:0] irq_sync;
    logic irq_lvl;
    logic irq_pulse;
  } dec_st_t;

  dec_st_t st_r;
  dec_st_t st_nxt;

  // No reset on the array: scratch contents survive a core reset
  logic [DATA_W-1:0] mem [RAM_DEPTH];
  logic [ADDR_W-1:0] tgt_addr;
  logic [DATA_W-1:0] mem_rd;
  logic mem_we;
  logic [DATA_W-1:0] mem_wdata;
  logic to_sfr;
  logic [2:0] bit_idx;

  rst_qual_if rq ();
  assign rq.reset_pin = reset_pin_i;

  reset_qualifier u_reset_qualifier (
    .ref_clk_i(ref_clk_i),
    .rst_n_i(rst_n_i),
    .rq(rq)
  );

  // Target byte decode
  always_comb begin
    bit_idx = acc_addr_i[2:0];
    to_sfr = 1'b0;
    case (acc_op_i)
      OP_DIR_RD, OP_DIR_WR: begin
        tgt_addr = acc_addr_i;
        to_sfr = acc_addr_i[SFR_SEL_BIT];
      end
      OP_IND_RD, OP_IND_WR: begin
        tgt_addr = acc_addr_i;
      end
      OP_REG_RD, OP_REG_WR: begin
        tgt_addr = {3'h0, psw_bank_i, acc_addr_i[2:0]};
      end
      OP_BIT_RD, OP_BIT_SET, OP_BIT_CLR: begin
        tgt_addr = bit_byte_addr(acc_addr_i);
        to_sfr = acc_addr_i[SFR_SEL_BIT];
      end
      default: begin
        tgt_addr = acc_addr_i;
      end
    endcase
    mem_rd = mem[tgt_addr];
  end

  always_comb begin
    st_nxt = st_r;
    st_nxt.core_rst = rq.core_rst;
    st_nxt.ack = 1'b0;
    st_nxt.err = 1'b0;
    st_nxt.sfr_req = 1'b0;
    st_nxt.irq_pulse = 1'b0;
    mem_we = 1'b0;
    mem_wdata = acc_wdata_i;

    // Pin passes three flops; a change counts when the last two agree
    st_nxt.irq_sync = {st_r.irq_sync[1:0], port1_bit0_irq_pin_i};
    if (st_r.irq_sync[1] == st_r.irq_sync[2] &&
        st_r.irq_sync[2] != st_r.irq_lvl) begin
      st_nxt.irq_lvl = st_r.irq_sync[2];
      // Falling edge always; rising only in both-edge mode
      st_nxt.irq_pulse = irq_both_edges_i || !st_r.irq_sync[2];
    end

    case (st_r.state)
      ST_IDLE: begin
        if (acc_req_i && to_sfr) begin
          st_nxt.sfr_req = 1'b1;
          st_nxt.sfr_addr = tgt_addr;
          st_nxt.sfr_wdata = acc_wdata_i;
          st_nxt.sfr_we = (acc_op_i == OP_DIR_WR);
          st_nxt.sfr_bit_idx = bit_idx;
          case (acc_op_i)
            OP_BIT_RD: st_nxt.sfr_bit_op = BITOP_READ;
            OP_BIT_SET: st_nxt.sfr_bit_op = BITOP_SET;
            OP_BIT_CLR: st_nxt.sfr_bit_op = BITOP_CLR;
            default: st_nxt.sfr_bit_op = BITOP_NONE;
          endcase
          st_nxt.state = ST_SFR_WAIT;
        end else if (acc_req_i) begin
          st_nxt.ack = 1'b1;
          st_nxt.rdata = mem_rd;
          st_nxt.bit_val = mem_rd[bit_idx];
          case (acc_op_i)
            OP_DIR_WR, OP_IND_WR, OP_REG_WR: begin
              mem_we = 1'b1;
            end
            OP_BIT_SET: begin
              mem_we = 1'b1;
              mem_wdata = mem_rd | (8'h01 << bit_idx);
            end
            OP_BIT_CLR: begin
              mem_we = 1'b1;
              mem_wdata = mem_rd & ~(8'h01 << bit_idx);
            end
            OP_DIR_RD, OP_IND_RD, OP_REG_RD, OP_BIT_RD: begin
              mem_we = 1'b0;
            end
            default: begin
              st_nxt.err = 1'b1;
            end
          endcase
        end
      end
      ST_SFR_WAIT: begin
        if (sfr_ack_i) begin
          st_nxt.ack = 1'b1;
          st_nxt.rdata = sfr_rdata_i;
          st_nxt.bit_val = sfr_rdata_i[st_r.sfr_bit_idx];
          st_nxt.state = ST_IDLE;
        end
      end
      default: begin
        st_nxt.state = ST_IDLE;
      end
    endcase

    // Qualified reset aborts accesses; interrupt sampling keeps running
    if (rq.core_rst) begin
      mem_we = 1'b0;
      st_nxt.state = ST_IDLE;
      st_nxt.ack = 1'b0;
      st_nxt.err = 1'b0;
      st_nxt.sfr_req = 1'b0;
      st_nxt.irq_pulse = 1'b0;
      st_nxt.rdata = RESET_BYTE;
    end
  end

  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      st_r <= '0;
      // Pin idles high: no false edge once reset lets go
      st_r.irq_sync <= 3'h7;
      st_r.irq_lvl <= 1'b1;
    end else begin
      st_r <= st_nxt;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (mem_we)
      mem[tgt_addr] <= mem_wdata;
  end

  assign core_rst_o = st_r.core_rst;
  assign acc_ack_o = st_r.ack;
  assign acc_err_o = st_r.err;
  assign acc_rdata_o = st_r.rdata;
  assign acc_bit_o = st_r.bit_val;
  assign sfr_req_o = st_r.sfr_req;
  assign sfr_we_o = st_r.sfr_we;
  assign sfr_addr_o = st_r.sfr_addr;
  assign sfr_wdata_o = st_r.sfr_wdata;
  assign sfr_bit_op_o = st_r.sfr_bit_op;
  assign sfr_bit_idx_o = st_r.sfr_bit_idx;
  assign ext_irq_one_o = st_r.irq_pulse;
endmodule
`default_nettype wire

// *** hdl/idm_pkg.sv ***
// Constants and types shared by the data memory decoder and its reset
// qualifier. Assumes a single 10 MHz core clock.
`default_nettype none
package idm_pkg;
  // Timing
  localparam int CLK_PERIOD_NS = 100;
  localparam int MACHINE_CYCLE_NS = 1000;
  localparam int RESET_HOLD_MC = 2;
  localparam int RESET_HOLD_NS = RESET_HOLD_MC * MACHINE_CYCLE_NS;
  localparam int RESET_HOLD_CYC =
    (RESET_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RESET_CNT_W = 5;
  // Memory geometry
  localparam int DATA_W = 8;
  localparam int ADDR_W = 8;
  localparam int RAM_DEPTH = 256;
  localparam int BANK_COUNT = 4;
  localparam int REGS_PER_BANK = 8;
  localparam int BIT_RAM_BYTES = 16;
  localparam logic [7:0] BIT_RAM_BASE = 8'(BANK_COUNT * REGS_PER_BANK);
  localparam logic [7:0] SFR_BASE = 8'h80;
  localparam int SFR_SEL_BIT = 7;
  localparam logic [7:0] RESET_BYTE = 8'h00;
  // Bit operation codes toward the special register space
  localparam logic [1:0] BITOP_NONE = 2'h0;
  localparam logic [1:0] BITOP_READ = 2'h1;
  localparam logic [1:0] BITOP_SET = 2'h2;
  localparam logic [1:0] BITOP_CLR = 2'h3;

  typedef enum logic [3:0] {
    OP_DIR_RD = 4'h0,
    OP_DIR_WR = 4'h1,
    OP_IND_RD = 4'h2,
    OP_IND_WR = 4'h3,
    OP_REG_RD = 4'h4,
    OP_REG_WR = 4'h5,
    OP_BIT_RD = 4'h6,
    OP_BIT_SET = 4'h7,
    OP_BIT_CLR = 4'h8
  } op_t;

  typedef enum logic [0:0] {
    ST_IDLE = 1'b0,
    ST_SFR_WAIT = 1'b1
  } acc_state_t;

  // Byte holding a bit; region base plus bit/8 below 80H, x0H/x8H above
  function automatic logic [7:0] bit_byte_addr(input logic [7:0] bit_addr);
    if (bit_addr[SFR_SEL_BIT])
      return {bit_addr[7:3], 3'h0};
    return BIT_RAM_BASE + {4'h0, bit_addr[6:3]};
  endfunction
endpackage
`default_nettype wire

// *** hdl/rst_qual_if.sv ***
// Carrier between the decoder and its reset qualifier.
// Assumes both ends share the core clock.
`default_nettype none
interface rst_qual_if;
  logic reset_pin;
  logic core_rst;
  modport qual (input reset_pin, output core_rst);
  modport user (output reset_pin, input core_rst);
endinterface
`default_nettype wire

// *** hdl/reset_qualifier.sv ***
// Reset pin qualifier: synchronises the pin and asserts the core reset
// after a long enough high level. Assumes the pin is asynchronous.
`default_nettype none
module reset_qualifier
  import idm_pkg::*;
(
  // Clock and reset
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  // Toward the decoder
  rst_qual_if.qual rq
);
  localparam logic [RESET_CNT_W-1:0] HOLD_CNT =
    RESET_CNT_W'(RESET_HOLD_CYC);

  typedef struct packed {
    logic [2:0] sync;
    logic [RESET_CNT_W-1:0] cnt;
    logic core_rst;
  } qual_st_t;

  qual_st_t st_r;
  qual_st_t st_nxt;

  always_comb begin
    st_nxt = st_r;
    st_nxt.sync = {st_r.sync[1:0], rq.reset_pin};
    // Glitches shorter than the hold time never reach the core
    if (st_r.sync[1] && st_r.sync[2]) begin
      if (st_r.cnt != HOLD_CNT)
        st_nxt.cnt = st_r.cnt + RESET_CNT_W'(1);
    end else if (!st_r.sync[1] && !st_r.sync[2]) begin
      st_nxt.cnt = '0;
    end
    st_nxt.core_rst = (st_nxt.cnt == HOLD_CNT);
  end

  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i)
      st_r <= '0;
    else
      st_r <= st_nxt;
  end

  assign rq.core_rst = st_r.core_rst;
endmodule
`default_nettype wire

// *** verif/idm_props.sv ***
// Checker for the data memory decoder, bound to its top module.
// Assumes one request in flight, as the access port allows.
`default_nettype none
module idm_props
  import idm_pkg::*;
(
  // Clock and reset
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  // Watched ports
  input wire logic reset_pin_i,
  input wire logic core_rst_o,
  input wire logic acc_req_i,
  input wire op_t acc_op_i,
  input wire logic [7:0] acc_addr_i,
  input wire logic acc_ack_o,
  input wire logic [7:0] acc_rdata_o,
  input wire logic sfr_req_o,
  input wire logic [7:0] sfr_addr_o,
  input wire logic [1:0] sfr_bit_op_o,
  input wire logic [2:0] sfr_bit_idx_o,
  input wire logic sfr_ack_i,
  input wire logic [7:0] sfr_rdata_i,
  input wire logic port1_bit0_irq_pin_i,
  input wire logic irq_both_edges_i,
  input wire logic ext_irq_one_o
);
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (!rst_n_i);
  logic wait_r;
  logic [4:0] hi_r;
  logic ok;
  // Requests during a pending special access are ignored
  assign ok = acc_req_i && !core_rst_o && !sfr_req_o &&
    !(wait_r && !acc_ack_o);
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      wait_r <= 1'b0;
      hi_r <= 5'h00;
    end else begin
      wait_r <= sfr_req_o || (wait_r && !acc_ack_o);
      hi_r <= !reset_pin_i ? 5'h00 : hi_r + 5'(hi_r != 5'h1f);
    end
  end
  a_ram_ack_next: assert property (
    ok && (acc_op_i inside {OP_IND_RD, OP_IND_WR} || !acc_addr_i[7] &&
    acc_op_i inside {OP_DIR_RD, OP_DIR_WR}) |=> acc_ack_o && !sfr_req_o)
    else $error("ram access not acknowledged");
  a_dir_to_sfr: assert property (
    ok && acc_addr_i[7] && acc_op_i inside {OP_DIR_RD, OP_DIR_WR} |=>
    sfr_req_o && !acc_ack_o && sfr_addr_o == $past(acc_addr_i))
    else $error("direct upper access not routed");
  a_sfr_bit_set: assert property (
    ok && acc_addr_i[7] && acc_op_i == OP_BIT_SET |=> sfr_req_o &&
    sfr_bit_op_o == BITOP_SET && sfr_addr_o == ($past(acc_addr_i) &
    8'hf8) && sfr_bit_idx_o == 3'($past(acc_addr_i)))
    else $error("special bit set badly forwarded");
  a_sfr_answer: assert property (
    sfr_ack_i && wait_r && !acc_ack_o |=> acc_ack_o &&
    acc_rdata_o == $past(sfr_rdata_i))
    else $error("special answer not returned");
  a_rst_hold_min: assert property (
    $rose(core_rst_o) |-> hi_r >= 5'h14)
    else $error("core reset after short pin pulse");
  a_rst_taken: assert property (
    hi_r == 5'h1e |-> core_rst_o)
    else $error("core reset missing");
  a_irq_fall_seen: assert property (
    $fell(port1_bit0_irq_pin_i) && !core_rst_o |-> ##[2:6] ext_irq_one_o)
    else $error("falling edge request missing");
  a_irq_rise_seen: assert property (
    $rose(port1_bit0_irq_pin_i) && irq_both_edges_i && !core_rst_o
    |-> ##[2:6] ext_irq_one_o)
    else $error("rising edge request missing");
endmodule
bind internal_data_memory_decoder idm_props i_idm_props (.*);
`default_nettype wire

// *** verif/sfr_model.sv ***
// Special register space stand-in: byte store with bit set and clear.
// Assumes one request at a time; answers lat_i cycles later.
`default_nettype none
module sfr_model
  import idm_pkg::*;
(
  // Clock and request
  input wire logic clk_i,
  input wire logic req_i,
  input wire logic we_i,
  input wire logic [7:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic [1:0] op_i,
  input wire logic [2:0] idx_i,
  input wire logic [3:0] lat_i,
  // Answer
  output logic ack_o,
  output logic [7:0] rdata_o
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] mem [128];
  logic [6:0] a;
  int n = 0;
  initial ack_o = 1'h0;
  initial rdata_o = 8'h00;
  always @(posedge clk_i) begin
    ack_o <= 1'h0;
    // Stale data must never look valid
    rdata_o <= ~rdata_o;
    if (req_i) begin
      n = lat_i;
      a = addr_i[6:0];
    end else if (n > 0) begin
      n--;
      if (n == 0) begin
        ack_o <= 1'h1;
        rdata_o <= mem[a];
        if (we_i) mem[a] <= wdata_i;
        if (op_i == BITOP_SET) mem[a][idx_i] <= 1'h1;
        if (op_i == BITOP_CLR) mem[a][idx_i] <= 1'h0;
      end
    end
  end
endmodule
`default_nettype wire

// *** verif/tb.sv ***
// Bench for the data memory decoder and a special register model.
// Assumes a 10 MHz clock; one access in flight at a time.
`default_nettype none
module tb;
  import idm_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  logic ref_clk_i = 1'h0, rst_n_i = 1'h0, reset_pin_i = 1'h0;
  logic acc_req_i = 1'h0, port1_bit0_irq_pin_i = 1'h1;
  logic irq_both_edges_i = 1'h0, sfr_ack_i;
  op_t acc_op_i = OP_DIR_RD;
  logic [7:0] acc_addr_i = 8'h00, acc_wdata_i = 8'h00, sfr_rdata_i;
  logic [1:0] psw_bank_i = 2'h0, sfr_bit_op_o;
  logic core_rst_o, acc_ack_o, acc_err_o, acc_bit_o, sfr_req_o, sfr_we_o;
  logic ext_irq_one_o;
  logic [7:0] acc_rdata_o, sfr_addr_o, sfr_wdata_o;
  logic [2:0] sfr_bit_idx_o;
  logic [3:0] lat = 4'h1;
  logic [7:0] ta [4] = '{8'h00, 8'h7f, 8'h80, 8'hff};
  int n_mismatch = 0, n_compared = 0, cyc = 0;
  internal_data_memory_decoder i_internal_data_memory_decoder (.*);
  sfr_model i_sfr_model (.clk_i(ref_clk_i), .req_i(sfr_req_o),
    .we_i(sfr_we_o), .addr_i(sfr_addr_o), .wdata_i(sfr_wdata_o),
    .op_i(sfr_bit_op_o), .idx_i(sfr_bit_idx_o), .lat_i(lat),
    .ack_o(sfr_ack_i), .rdata_o(sfr_rdata_i));
  initial forever #50 ref_clk_i = ~ref_clk_i;
  task automatic final_report;
    if (n_mismatch == 0 && n_compared > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  always @(posedge ref_clk_i) begin
    cyc++;
    if (cyc == 20000) begin
      n_mismatch++;
      final_report;
    end
  end
  task automatic chk(input string nm, input logic [7:0] e, g);
    n_compared++;
    if (g !== e) begin
      n_mismatch++;
      $display("mismatch %s exp %h got %h", nm, e, g);
    end
  endtask
  task automatic acc(input op_t o, input logic [7:0] a, w);
    int k;
    @(posedge ref_clk_i);
    acc_req_i <= 1'h1;
    acc_op_i <= o;
    acc_addr_i <= a;
    acc_wdata_i <= w;
    @(posedge ref_clk_i);
    acc_req_i <= 1'h0;
    k = 0;
    do begin
      @(negedge ref_clk_i);
      k++;
    end while (acc_ack_o !== 1'h1 && k < 40);
    if (k == 40) n_mismatch++;
  endtask
  task automatic t_map;
    foreach (ta[i]) acc(OP_IND_WR, ta[i], ~ta[i]);
    foreach (ta[i]) if (ta[i][7]) acc(OP_DIR_WR, ta[i], 8'h5a);
    foreach (ta[i]) begin
      acc(OP_IND_RD, ta[i], 8'h00);
      chk("ind", ~ta[i], acc_rdata_o);
      chk("noerr", 8'h00, 8'(acc_err_o));
      acc(OP_DIR_RD, ta[i], 8'h00);
      chk("dir", ta[i][7] ? 8'h5a : ~ta[i], acc_rdata_o);
    end
  endtask
  task automatic t_bank;
    for (int b = 0; b < 4; b++) begin
      @(posedge ref_clk_i);
      psw_bank_i <= 2'(b);
      acc(OP_REG_WR, 8'h07, 8'(b) ^ 8'hc0);
      acc(OP_IND_RD, 8'(b * 8 + 7), 8'h00);
      chk("bank", 8'(b) ^ 8'hc0, acc_rdata_o);
      acc(OP_REG_RD, 8'h07, 8'h00);
      chk("reg", 8'(b) ^ 8'hc0, acc_rdata_o);
    end
  endtask
  task automatic t_bit;
    acc(OP_IND_WR, 8'h21, 8'h00);
    acc(OP_BIT_SET, 8'h0b, 8'h00);
    acc(OP_BIT_RD, 8'h0b, 8'h00);
    chk("bit", 8'h01, 8'(acc_bit_o));
    acc(OP_IND_RD, 8'h21, 8'h00);
    chk("bitbyte", 8'h08, acc_rdata_o);
    acc(OP_BIT_CLR, 8'h0b, 8'h00);
    acc(OP_IND_RD, 8'h21, 8'h00);
    chk("bitclr", 8'h00, acc_rdata_o);
    lat <= 4'h3;
    acc(OP_DIR_WR, 8'h90, 8'h00);
    acc(OP_BIT_SET, 8'h94, 8'h00);
    acc(OP_DIR_RD, 8'h90, 8'h00);
    chk("sfrbit", 8'h10, acc_rdata_o);
    acc(OP_BIT_RD, 8'h94, 8'h00);
    chk("sfrbitrd", 8'h01, 8'(acc_bit_o));
    acc(OP_BIT_CLR, 8'h94, 8'h00);
    acc(OP_DIR_RD, 8'h90, 8'h00);
    chk("sfrbitclr", 8'h00, acc_rdata_o);
    acc(op_t'(4'h9), 8'h00, 8'h00);
    chk("err", 8'h01, 8'(acc_err_o));
  endtask
  task automatic t_irq(input logic b, v, input logic [7:0] e);
    logic [7:0] c;
    c = 8'h00;
    @(posedge ref_clk_i);
    irq_both_edges_i <= b;
    port1_bit0_irq_pin_i <= v;
    repeat (10) begin
      @(negedge ref_clk_i);
      if (ext_irq_one_o === 1'h1) c++;
    end
    chk("irq", e, c);
  endtask
  task automatic t_rst;
    logic [7:0] c;
    c = 8'h00;
    @(posedge ref_clk_i);
    reset_pin_i <= 1'h1;
    repeat (12) @(posedge ref_clk_i);
    reset_pin_i <= 1'h0;
    repeat (20) begin
      @(negedge ref_clk_i);
      if (core_rst_o === 1'h1) c++;
    end
    chk("short", 8'h00, c);
    @(posedge ref_clk_i);
    reset_pin_i <= 1'h1;
    repeat (32) @(negedge ref_clk_i);
    chk("long", 8'h01, 8'(core_rst_o));
    chk("rstdata", 8'h00, acc_rdata_o);
    @(posedge ref_clk_i);
    reset_pin_i <= 1'h0;
    repeat (12) @(negedge ref_clk_i);
    chk("drop", 8'h00, 8'(core_rst_o));
    acc(OP_IND_RD, 8'h80, 8'h00);
    chk("kept", 8'h7f, acc_rdata_o);
  endtask
  initial begin
    repeat (6) @(posedge ref_clk_i);
    rst_n_i <= 1'h1;
    t_map;
    t_bank;
    t_bit;
    t_irq(1'h0, 1'h0, 8'h01);
    t_irq(1'h0, 1'h1, 8'h00);
    t_irq(1'h1, 1'h0, 8'h01);
    t_irq(1'h1, 1'h1, 8'h01);
    t_rst;
    final_report;
  end
endmodule
`default_nettype wire
